// *** common/fe_pkg.sv ***
// forwarding engine shared constants, types and helpers
package fe_pkg;
  localparam logic [7:0] ADDR_FWD_PORT = 8'h20;
  localparam logic [7:0] ADDR_FWD_MODE = 8'h21;
  localparam logic [7:0] ADDR_TX_CTL = 8'h33;
  localparam logic [7:0] ADDR_TX_CAL = 8'h34;
  localparam logic [7:0] ADDR_TX_STAT = 8'h35;
  localparam logic [7:0] ADDR_VC_MAP = 8'h40;
  localparam logic [7:0] RST_FWD_PORT = 8'h30;
  localparam logic [7:0] RST_FWD_MODE = 8'h00;
  localparam logic [7:0] RST_TX_CTL = 8'h00;
  localparam logic [7:0] RST_TX_CAL = 8'h00;
  localparam logic [7:0] RST_VC_MAP = 8'h04;
  localparam logic [7:0] VAL_ZERO = 8'h00;
  localparam int BIT_TX_EN = 0;
  localparam int BIT_CONT_CLK = 1;
  localparam int BIT_CAL_EN = 0;
  localparam int BIT_RR = 0;
  localparam int SYNC_LO = 2;
  localparam int OFF_LO = 4;
  localparam int BIT_STAT_SYNC = 0;
  localparam int BIT_STAT_LOST = 1;
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [5:0] DT_LONG_MIN = 6'h10;
  localparam logic [15:0] HDR_LAST = 16'h0003;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam logic [2:0] LINK_HALF = 3'(LINK_PERIOD_NS / CLK_PERIOD_NS / 2);
  localparam logic [2:0] LINK_DIV_LAST = 3'(LINK_PERIOD_NS / CLK_PERIOD_NS - 1);
  localparam int LINE_WINDOW_NS = 64000;
  localparam logic [11:0] LINE_WINDOW_CYCLES = 12'(LINE_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [2:0] SEQ_START_LAST = 3'h4;
  localparam logic [2:0] SEQ_STOP_LAST = 3'h3;

  typedef enum logic [1:0] {FE_SYNC_OFF, FE_SYNC_BASIC, FE_SYNC_INTERLEAVE, FE_SYNC_CONCAT} fe_sync_t;
  typedef enum logic [1:0] {FE_KIND_FS, FE_KIND_FE, FE_KIND_LINE, FE_KIND_OTHER} fe_kind_t;

  function automatic fe_kind_t fe_kind(input logic [5:0] dt);
    if (dt == DT_FS) return FE_KIND_FS;
    if (dt == DT_FE) return FE_KIND_FE;
    if (dt >= DT_LONG_MIN) return FE_KIND_LINE;
    return FE_KIND_OTHER;
  endfunction

  // simplified check byte, not a full error-correcting code
  function automatic logic [7:0] fe_check(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    return a ^ b ^ c;
  endfunction
endpackage

// *** common/fe_link_if.sv ***
// register port and output lanes between the engine and the video host
`timescale 1ns/100ps
interface fe_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic lane_en;
  logic lane_hs;
  logic lane_clk;
  logic [7:0] lane_byte;
  modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata,
               output reg_rdata, reg_ack, lane_en, lane_hs, lane_clk, lane_byte);
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_ack, lane_en, lane_hs, lane_clk, lane_byte);
endinterface

// *** hdl/fe_forward_engine.sv ***
// forwarding engine: buffers to output lanes, with register file
`timescale 1ns/100ps
// Notes on behaviour
// R1: forward buffer packets, make lane transitions
// R2: watch buffers for complete packet availability
// R3: per port disable stops its forwarding
// R4: engine draws either buffer, independently
// R5: transmitter enable puts lanes in stop state
// R6: software stops in four ordered steps
// R7: software starts in three ordered steps; the host start sequence writes five ordered steps (step 0 to SEQ_START_LAST)
// R8: best effort sends promptly, round robin
// R9: best effort uses channel ids, no alignment
// R10: best effort runs when its bit set
// R11: synced mode orders port 0 before 1
// R12: synced sources aligned, identical video format
// R13: on sync failure discard until frame start
// R14: synced status plus read-cleared lost flag
// R15: synced field selects three variants
// R16: software enters synced mode in three steps
// R17: basic mode pairs starts, lines, ends
// R18: basic mode tags packets with port channel
// R19: interleave keeps only port 0 sync packets
// R20: interleave sources share one channel id; in interleave the engine tags each port with its own channel from vc_map_r
// R21: no pull until whole packet present
// R22: synced status reads zero when off
// R23: missing partner packet within line fails
module fe_forward_engine import fe_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_in,
  fe_link_if.dev link,
  input wire logic [1:0] buf_ready_in,
  input wire logic [1:0][5:0] buf_dt_in,
  input wire logic [1:0][15:0] buf_len_in,
  input wire logic [1:0][7:0] buf_data_in,
  output logic [1:0] buf_pop_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAY, ST_END, ST_DROP} fe_state_t;

  logic [7:0] port_ctl_r, port_ctl_nxt, mode_ctl_r, mode_ctl_nxt, tx_ctl_r, tx_ctl_nxt;
  logic [7:0] cal_ctl_r, cal_ctl_nxt, vc_map_r, vc_map_nxt, rdata_r, rdata_nxt;
  logic ack_r, ack_nxt, lost_r, lost_nxt, lost_set;
  fe_state_t state_r, state_nxt;
  logic sel_r, sel_nxt, want_r, want_nxt, last_r, last_nxt, sync_ok_r, sync_ok_nxt;
  logic hs_r, hs_nxt, clk_r, clk_nxt;
  logic [15:0] idx_r, idx_nxt, len_r, len_nxt;
  logic [5:0] dt_r, dt_nxt;
  logic [1:0] vc_r, vc_nxt;
  fe_kind_t ref_kind_r, ref_kind_nxt;
  logic [11:0] wait_r, wait_nxt;
  logic [2:0] div_r, div_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic tx_en, tick, paired, one_pop, pick;
  logic [1:0] enabled, avail, fs_head;
  fe_sync_t sync_mode;

  assign tx_en = tx_ctl_r[BIT_TX_EN];
  assign enabled = ~port_ctl_r[OFF_LO +: 2];
  assign sync_mode = fe_sync_t'(mode_ctl_r[SYNC_LO +: 2]); // R15
  assign avail = buf_ready_in & enabled; // R2 R3 R21
  assign fs_head = {fe_kind(buf_dt_in[1]) == FE_KIND_FS, fe_kind(buf_dt_in[0]) == FE_KIND_FS};
  assign tick = (div_r == LINK_DIV_LAST);
  assign paired = (enabled == 2'b11);
  assign one_pop = (fe_kind(dt_r) != FE_KIND_LINE) || (len_r == 16'h0000);

  // register file
  always_comb begin
    port_ctl_nxt = port_ctl_r;
    mode_ctl_nxt = mode_ctl_r;
    tx_ctl_nxt = tx_ctl_r;
    cal_ctl_nxt = cal_ctl_r;
    vc_map_nxt = vc_map_r;
    rdata_nxt = rdata_r;
    ack_nxt = link.reg_rd;
    // set wins over the read that clears
    lost_nxt = lost_set | (lost_r & ~(link.reg_rd && link.reg_addr == ADDR_TX_STAT)); // R14
    if (link.reg_wr) begin
      case (link.reg_addr)
        ADDR_FWD_PORT: port_ctl_nxt = link.reg_wdata;
        ADDR_FWD_MODE: mode_ctl_nxt = link.reg_wdata;
        ADDR_TX_CTL: tx_ctl_nxt = link.reg_wdata;
        ADDR_TX_CAL: cal_ctl_nxt = link.reg_wdata;
        ADDR_VC_MAP: vc_map_nxt = link.reg_wdata;
        default: ;
      endcase
    end
    if (link.reg_rd) begin
      case (link.reg_addr)
        ADDR_FWD_PORT: rdata_nxt = port_ctl_r;
        ADDR_FWD_MODE: rdata_nxt = mode_ctl_r;
        ADDR_TX_CTL: rdata_nxt = tx_ctl_r;
        ADDR_TX_CAL: rdata_nxt = cal_ctl_r;
        ADDR_VC_MAP: rdata_nxt = vc_map_r;
        ADDR_TX_STAT: begin
          rdata_nxt = VAL_ZERO;
          rdata_nxt[BIT_STAT_SYNC] = sync_ok_r && (sync_mode != FE_SYNC_OFF); // R22 R14
          rdata_nxt[BIT_STAT_LOST] = lost_r;
        end
        default: rdata_nxt = VAL_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port_ctl_r <= RST_FWD_PORT;
      mode_ctl_r <= RST_FWD_MODE;
      tx_ctl_r <= RST_TX_CTL;
      cal_ctl_r <= RST_TX_CAL;
      vc_map_r <= RST_VC_MAP;
      rdata_r <= VAL_ZERO;
      ack_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      port_ctl_r <= port_ctl_nxt;
      mode_ctl_r <= mode_ctl_nxt;
      tx_ctl_r <= tx_ctl_nxt;
      cal_ctl_r <= cal_ctl_nxt;
      vc_map_r <= vc_map_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      lost_r <= lost_nxt;
    end
  end

  // forwarding engine
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    want_nxt = want_r;
    last_nxt = last_r;
    sync_ok_nxt = sync_ok_r;
    hs_nxt = hs_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    dt_nxt = dt_r;
    vc_nxt = vc_r;
    ref_kind_nxt = ref_kind_r;
    wait_nxt = wait_r;
    byte_nxt = byte_r;
    buf_pop_out = 2'b00;
    lost_set = 1'b0;
    pick = 1'b0;
    div_nxt = tx_en ? 3'(div_r + 3'h1) : 3'h0;
    case (state_r)
      ST_IDLE: begin
        if (sync_mode == FE_SYNC_OFF) begin
          sync_ok_nxt = 1'b0;
          if (tx_en && mode_ctl_r[BIT_RR]) begin // R10
            pick = avail[~last_r] ? ~last_r : last_r; // R8
            if (avail[pick]) begin
              last_nxt = pick;
              state_nxt = ST_HDR;
            end
          end
        end else if (tx_en && !sync_ok_r) begin
          // resync only when every enabled port heads with a frame start
          if (enabled != 2'b00 && (avail & fs_head) == enabled) begin // R13
            sync_ok_nxt = 1'b1;
            want_nxt = ~enabled[0]; // R11
            wait_nxt = 12'h000;
          end else if (avail[0] && !fs_head[0]) begin
            pick = 1'b0;
            state_nxt = ST_DROP; // R13
          end else if (avail[1] && !fs_head[1]) begin
            pick = 1'b1;
            state_nxt = ST_DROP;
          end
        end else if (tx_en) begin
          pick = want_r;
          if (avail[pick]) begin
            if (paired && pick && fe_kind(buf_dt_in[1]) != ref_kind_r) begin
              sync_ok_nxt = 1'b0;
              lost_set = 1'b1;
            end else begin
              ref_kind_nxt = fe_kind(buf_dt_in[pick]);
              want_nxt = enabled[~pick] ? ~pick : pick; // R11 R17
              wait_nxt = 12'h000;
              if (sync_mode != FE_SYNC_BASIC && paired && pick && fe_kind(buf_dt_in[1]) != FE_KIND_LINE)
                state_nxt = ST_DROP; // R19
              else
                state_nxt = ST_HDR;
            end
          end else if (paired && pick) begin
            wait_nxt = 12'(wait_r + 12'h001);
            if (wait_r == LINE_WINDOW_CYCLES - 12'h001) begin // R23
              sync_ok_nxt = 1'b0;
              lost_set = 1'b1;
            end
          end
        end
        if (state_nxt != ST_IDLE) begin
          sel_nxt = pick; // R4
          dt_nxt = buf_dt_in[pick];
          len_nxt = buf_len_in[pick];
          idx_nxt = 16'h0000;
          // concatenation takes the lowest port's channel
          vc_nxt = (sync_mode == FE_SYNC_CONCAT) ? vc_map_r[1:0] : vc_map_r[2 * pick +: 2]; // R18 R9
          if (state_nxt == ST_DROP && (fe_kind(buf_dt_in[pick]) != FE_KIND_LINE || buf_len_in[pick] == 16'h0000))
            len_nxt = 16'h0001;
        end
      end
      ST_HDR: begin
        if (tick) begin // R1
          hs_nxt = 1'b1;
          case (idx_r[1:0])
            2'h0: byte_nxt = {vc_r, dt_r};
            2'h1: byte_nxt = len_r[7:0];
            2'h2: byte_nxt = len_r[15:8];
            default: byte_nxt = fe_check({vc_r, dt_r}, len_r[7:0], len_r[15:8]);
          endcase
          if (idx_r == 16'h0000 && one_pop)
            buf_pop_out[sel_r] = 1'b1;
          idx_nxt = 16'(idx_r + 16'h0001);
          if (idx_r == HDR_LAST) begin
            idx_nxt = 16'h0000;
            state_nxt = one_pop ? ST_END : ST_PAY;
          end
        end
      end
      ST_PAY: begin
        if (tick) begin
          byte_nxt = buf_data_in[sel_r];
          buf_pop_out[sel_r] = 1'b1;
          idx_nxt = 16'(idx_r + 16'h0001);
          if (idx_r == 16'(len_r - 16'h0001))
            state_nxt = ST_END;
        end
      end
      ST_END: begin
        if (tick) begin
          hs_nxt = 1'b0; // R1 R5
          state_nxt = ST_IDLE;
        end
      end
      ST_DROP: begin
        buf_pop_out[sel_r] = 1'b1;
        idx_nxt = 16'(idx_r + 16'h0001);
        if (idx_r == 16'(len_r - 16'h0001))
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // dropping the enable aborts the burst straight to stop state
    if (!tx_en) begin
      if (state_r != ST_DROP)
        state_nxt = ST_IDLE;
      hs_nxt = 1'b0;
    end
    clk_nxt = tx_en && (hs_nxt || tx_ctl_r[BIT_CONT_CLK]) && (div_nxt >= LINK_HALF);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      sel_r <= 1'b0;
      want_r <= 1'b0;
      last_r <= 1'b1;
      sync_ok_r <= 1'b0;
      hs_r <= 1'b0;
      clk_r <= 1'b0;
      idx_r <= 16'h0000;
      len_r <= 16'h0000;
      dt_r <= 6'h00;
      vc_r <= 2'h0;
      ref_kind_r <= FE_KIND_FS;
      wait_r <= 12'h000;
      div_r <= 3'h0;
      byte_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      want_r <= want_nxt;
      last_r <= last_nxt;
      sync_ok_r <= sync_ok_nxt;
      hs_r <= hs_nxt;
      clk_r <= clk_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      dt_r <= dt_nxt;
      vc_r <= vc_nxt;
      ref_kind_r <= ref_kind_nxt;
      wait_r <= wait_nxt;
      div_r <= div_nxt;
      byte_r <= byte_nxt;
    end
  end

  assign link.reg_rdata = rdata_r;
  assign link.reg_ack = ack_r;
  assign link.lane_en = tx_en; // R5
  assign link.lane_hs = hs_r;
  assign link.lane_clk = clk_r;
  assign link.lane_byte = byte_r;
endmodule // fe_forward_engine

// *** hdl/fe_video_host.sv ***
// video host: register sequencing and lane receiver
`timescale 1ns/100ps
module fe_video_host import fe_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_in,
  fe_link_if.host link,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic status_req_in,
  input wire logic [1:0] sync_mode_in,
  input wire logic rr_in,
  input wire logic cal_in,
  input wire logic cont_clk_in,
  output logic busy_out,
  output logic [7:0] status_out,
  output logic status_valid_out,
  output logic rx_valid_out,
  output logic rx_first_out,
  output logic [7:0] rx_byte_out
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_STOP, H_READ, H_WAIT} fe_host_state_t;

  fe_host_state_t st_r, st_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] cfg_r, cfg_nxt, status_r, status_nxt, rx_byte_r, rx_byte_nxt;
  logic status_valid_r, status_valid_nxt, rx_valid_r, rx_valid_nxt, rx_first_r, rx_first_nxt;
  logic in_pkt_r, in_pkt_nxt;
  logic [2:0] clk_s_r, clk_s_nxt, hs_s_r, hs_s_nxt;
  logic [1:0][7:0] byte_s_r, byte_s_nxt;
  logic wr, rd;
  logic [7:0] addr, wdata;

  // cfg_r holds {cal, cont, rr, sync[1:0]} captured at start
  always_comb begin
    st_nxt = st_r;
    step_nxt = step_r;
    cfg_nxt = cfg_r;
    status_nxt = status_r;
    status_valid_nxt = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = VAL_ZERO;
    wdata = VAL_ZERO;
    case (st_r)
      H_IDLE: begin
        step_nxt = 3'h0;
        if (start_in) begin
          st_nxt = H_START;
          cfg_nxt = {3'h0, cal_in, cont_clk_in, rr_in, sync_mode_in};
        end else if (stop_in)
          st_nxt = H_STOP;
        else if (status_req_in)
          st_nxt = H_READ;
      end
      H_START: begin
        wr = 1'b1;
        case (step_r)
          3'h0: begin // R7
            addr = ADDR_TX_CTL;
            wdata[BIT_TX_EN] = 1'b1;
            wdata[BIT_CONT_CLK] = cfg_r[3];
          end
          3'h1: begin
            addr = ADDR_TX_CAL;
            wdata[BIT_CAL_EN] = cfg_r[4];
          end
          3'h2: begin // R16
            addr = ADDR_FWD_MODE;
            wdata[BIT_RR] = cfg_r[2];
          end
          3'h3: addr = ADDR_FWD_PORT;
          default: begin
            addr = ADDR_FWD_MODE;
            wdata[BIT_RR] = cfg_r[2] && (cfg_r[1:0] == 2'h0);
            wdata[SYNC_LO +: 2] = cfg_r[1:0];
          end
        endcase
        step_nxt = 3'(step_r + 3'h1);
        if (step_r == SEQ_START_LAST)
          st_nxt = H_IDLE;
      end
      H_STOP: begin
        wr = 1'b1;
        case (step_r) // R6
          3'h0: begin
            addr = ADDR_FWD_PORT;
            wdata = RST_FWD_PORT;
          end
          3'h1: addr = ADDR_TX_CAL;
          3'h2: begin
            addr = ADDR_TX_CTL;
            wdata[BIT_TX_EN] = 1'b1;
          end
          default: addr = ADDR_TX_CTL;
        endcase
        step_nxt = 3'(step_r + 3'h1);
        if (step_r == SEQ_STOP_LAST)
          st_nxt = H_IDLE;
      end
      H_READ: begin
        rd = 1'b1;
        addr = ADDR_TX_STAT;
        st_nxt = H_WAIT;
      end
      H_WAIT: begin
        if (link.reg_ack) begin
          status_nxt = link.reg_rdata;
          status_valid_nxt = 1'b1;
          st_nxt = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  // lane pins cross in through two flops before any use
  always_comb begin
    clk_s_nxt = {clk_s_r[1:0], link.lane_clk};
    hs_s_nxt = {hs_s_r[1:0], link.lane_hs};
    byte_s_nxt = {byte_s_r[0], link.lane_byte};
    rx_valid_nxt = 1'b0;
    rx_first_nxt = 1'b0;
    rx_byte_nxt = rx_byte_r;
    in_pkt_nxt = in_pkt_r;
    if (!hs_s_r[1])
      in_pkt_nxt = 1'b0;
    // data is steady at the rising lane clock edge
    if (clk_s_r[1] && !clk_s_r[2] && hs_s_r[1]) begin
      rx_valid_nxt = 1'b1;
      rx_first_nxt = !in_pkt_r;
      rx_byte_nxt = byte_s_r[1];
      in_pkt_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= H_IDLE;
      step_r <= 3'h0;
      cfg_r <= VAL_ZERO;
      status_r <= VAL_ZERO;
      status_valid_r <= 1'b0;
      clk_s_r <= 3'h0;
      hs_s_r <= 3'h0;
      byte_s_r <= '0;
      rx_valid_r <= 1'b0;
      rx_first_r <= 1'b0;
      rx_byte_r <= VAL_ZERO;
      in_pkt_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      step_r <= step_nxt;
      cfg_r <= cfg_nxt;
      status_r <= status_nxt;
      status_valid_r <= status_valid_nxt;
      clk_s_r <= clk_s_nxt;
      hs_s_r <= hs_s_nxt;
      byte_s_r <= byte_s_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_first_r <= rx_first_nxt;
      rx_byte_r <= rx_byte_nxt;
      in_pkt_r <= in_pkt_nxt;
    end
  end

  assign link.reg_wr = wr;
  assign link.reg_rd = rd;
  assign link.reg_addr = addr;
  assign link.reg_wdata = wdata;
  assign busy_out = (st_r != H_IDLE);
  assign status_out = status_r;
  assign status_valid_out = status_valid_r;
  assign rx_valid_out = rx_valid_r;
  assign rx_first_out = rx_first_r;
  assign rx_byte_out = rx_byte_r;
endmodule // fe_video_host

// *** testbench/fe_props.sv ***
// concurrent checks on the link between engine and host
`timescale 1ns/100ps
module fe_props import fe_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic lane_en,
  input wire logic lane_hs,
  input wire logic lane_clk,
  input wire logic [7:0] lane_byte
);
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // shadow of the sync mode field, for the status check
  always_comb begin
    sync_nxt = sync_r;
    if (reg_wr && reg_addr == ADDR_FWD_MODE) sync_nxt = reg_wdata[SYNC_LO+:2];
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) sync_r <= 2'h0;
    else sync_r <= sync_nxt;
  end
  property p_rd_ack;
    reg_rd |=> reg_ack ##1 !reg_ack;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read ack late");
  property p_ack_cause;
    reg_ack |-> $past(reg_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without read");
  property p_en_set;
    reg_wr && reg_addr == ADDR_TX_CTL && reg_wdata[BIT_TX_EN] |=> lane_en;
  endproperty
  a_en_set: assert property (p_en_set) else $error("lanes not enabled");
  property p_en_stop;
    $rose(lane_en) |-> !lane_hs;
  endproperty
  a_en_stop: assert property (p_en_stop) else $error("enable not in stop state");
  property p_hs_off;
    !lane_en && !$past(lane_en) |-> !lane_hs;
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("burst while disabled");
  property p_burst_min;
    $rose(lane_hs) |-> lane_hs[*8];
  endproperty
  a_burst_min: assert property (p_burst_min) else $error("burst too short");
  property p_clk_high;
    $rose(lane_clk) |-> lane_clk[*4] ##1 !lane_clk;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high phase");
  property p_byte_steady;
    $rose(lane_clk) |-> $stable(lane_byte)[*4];
  endproperty
  a_byte_steady: assert property (p_byte_steady) else $error("byte moved under clock");
  property p_hs_clk;
    $rose(lane_hs) |-> !lane_clk ##[3:5] lane_clk;
  endproperty
  a_hs_clk: assert property (p_hs_clk) else $error("first clock edge late");
  property p_stat_off;
    reg_rd && reg_addr == ADDR_TX_STAT && sync_r == 2'h0 |=> !reg_rdata[BIT_STAT_SYNC];
  endproperty
  a_stat_off: assert property (p_stat_off) else $error("synced while off");
  c_burst: cover property ($rose(lane_hs));
  c_stat: cover property (reg_rd && reg_addr == ADDR_TX_STAT);
  c_en: cover property ($rose(lane_en));
endmodule // fe_props

// *** testbench/testbench.sv ***
// self-checking bench joining engine and host across the link
`timescale 1ns/100ps
module testbench import fe_pkg::*; ;
  typedef struct packed {logic [5:0] dt; logic [15:0] len;} fe_pk_t;
  logic clock_in, rst_in, start_in, stop_in, status_req_in, rr_in, cal_in, cont_clk_in;
  logic [1:0] sync_mode_in, buf_ready_in, buf_pop_out;
  logic [1:0][5:0] buf_dt_in;
  logic [1:0][15:0] buf_len_in;
  logic [1:0][7:0] buf_data_in;
  logic busy_out, status_valid_out, rx_valid_out, rx_first_out;
  logic [7:0] status_out, rx_byte_out, eb, em;
  logic [15:0] fa, fb;
  fe_pk_t bq[2][$];
  logic [7:0] eb_q[$], em_q[$], st_q[$];
  int bad_count, comparisons;
  fe_link_if link();
  fe_forward_engine fe_forward_engine_inst(.clock_in(clock_in), .rst_in(rst_in), .link(link),
    .buf_ready_in(buf_ready_in), .buf_dt_in(buf_dt_in), .buf_len_in(buf_len_in),
    .buf_data_in(buf_data_in), .buf_pop_out(buf_pop_out));
  fe_video_host fe_video_host_inst(.clock_in(clock_in), .rst_in(rst_in), .link(link),
    .start_in(start_in), .stop_in(stop_in), .status_req_in(status_req_in), .sync_mode_in(sync_mode_in),
    .rr_in(rr_in), .cal_in(cal_in), .cont_clk_in(cont_clk_in), .busy_out(busy_out),
    .status_out(status_out), .status_valid_out(status_valid_out), .rx_valid_out(rx_valid_out),
    .rx_first_out(rx_first_out), .rx_byte_out(rx_byte_out));
  fe_props fe_props_inst(.clock_in(clock_in), .rst_in(rst_in), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_ack(link.reg_ack), .lane_en(link.lane_en), .lane_hs(link.lane_hs),
    .lane_clk(link.lane_clk), .lane_byte(link.lane_byte));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out();
    $display("counts comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // buffer heads hold only whole packets; idle heads carry noise
  always @(posedge clock_in) begin
    for (int p = 0; p < 2; p++)
      if (buf_pop_out[p] === 1'b1 && bq[p].size() > 0) void'(bq[p].pop_front());
    #1;
    for (int p = 0; p < 2; p++) begin
      buf_ready_in[p] = bq[p].size() > 0;
      buf_dt_in[p] = bq[p].size() > 0 ? bq[p][0].dt : 6'($urandom);
      buf_len_in[p] = bq[p].size() > 0 ? bq[p][0].len : 16'($urandom);
      buf_data_in[p] = 8'($urandom);
    end
  end
  always @(posedge clock_in) begin
    if (rx_valid_out === 1'b1) begin
      if (eb_q.size() == 0) chk("rx_extra", ~rx_byte_out, rx_byte_out);
      else begin
        // every expected burst is four header bytes, so a burst opens on a multiple of four
        chk("rx_first", {7'h00, eb_q.size() % 4 == 0}, {7'h00, rx_first_out});
        eb = eb_q.pop_front();
        em = em_q.pop_front();
        chk("rx_byte", eb & em, rx_byte_out & em);
      end
    end
    if (status_valid_out === 1'b1 && st_q.size() > 0) chk("status", st_q.pop_front(), status_out & 8'h03);
  end
  task put(input int p, input logic [5:0] dt, input logic [15:0] ln);
    bq[p].push_back({dt, ln});
  endtask
  // header bytes as seen on the lanes, channel from the reset map
  task ex(input int p, input logic [5:0] dt, input logic [15:0] ln, input logic [7:0] m);
    logic [7:0] b0;
    b0 = {RST_VC_MAP[2*p+:2], dt};
    eb_q.push_back(b0);
    em_q.push_back(m);
    eb_q.push_back(ln[7:0]);
    em_q.push_back(8'hFF);
    eb_q.push_back(ln[15:8]);
    em_q.push_back(8'hFF);
    eb_q.push_back(b0 ^ ln[7:0] ^ ln[15:8]);
    em_q.push_back(m);
  endtask
  task waitb();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("busy", 8'h00, {7'h00, busy_out});
  endtask
  task host(input int k);
    waitb();
    case (k)
      0: start_in = 1'b1;
      1: stop_in = 1'b1;
      default: status_req_in = 1'b1;
    endcase
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    stop_in = 1'b0;
    status_req_in = 1'b0;
    @(posedge clock_in);
    #1;
    waitb();
  endtask
  task run(input logic [1:0] md, input logic rr);
    sync_mode_in = md;
    rr_in = rr;
    cal_in = 1'($urandom);
    host(0);
  endtask
  task stat(input logic [7:0] e);
    st_q.push_back(e);
    host(2);
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task drain();
    int n;
    n = 0;
    while (eb_q.size() > 0 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    chk("drain", 8'h00, 8'(eb_q.size()));
    repeat (40) @(posedge clock_in);
    #1;
  endtask
  // one frame from each port; interleave drops port 1 sync packets
  task frame(input logic [1:0] md);
    int p;
    logic [5:0] dt;
    logic [15:0] ln;
    for (int i = 0; i < 6; i++) begin
      p = i % 2;
      dt = i < 2 ? DT_FS : (i < 4 ? 6'h2A : DT_FE);
      ln = (i == 2 || i == 3) ? 16'h0000 : 16'($urandom);
      put(p, dt, ln);
      if (md == 2'h1 || p == 0 || i == 2 || i == 3) ex(p, dt, ln, (p == 1 && md != 2'h1) ? 8'h3F : 8'hFF);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clock_in);
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hA41E));
    {start_in, stop_in, status_req_in, rr_in, cal_in, cont_clk_in} = 6'h00;
    sync_mode_in = 2'h0;
    rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    chk("lane_en", 8'h00, {7'h00, link.lane_en});
    stat(8'h00);
    fa = 16'($urandom);
    put(0, DT_FS, fa);
    repeat (100) @(posedge clock_in);
    #1;
    chk("held", 8'h01, 8'(bq[0].size()));
    $display("test reset done");
    ex(0, DT_FS, fa, 8'hFF);
    run(2'h0, 1'b1);
    repeat (10) @(posedge clock_in);
    fa = 16'($urandom);
    fb = 16'($urandom);
    put(0, DT_FE, fa);
    put(1, DT_FS, fb);
    ex(1, DT_FS, fb, 8'hFF);
    ex(0, DT_FE, fa, 8'hFF);
    drain();
    chk("stop_state", 8'h01, {6'h00, link.lane_hs, link.lane_en});
    stat(8'h00);
    host(1);
    chk("lane_off", 8'h00, {7'h00, link.lane_en});
    $display("test best effort done");
    run(2'h1, 1'b0);
    frame(2'h1);
    drain();
    stat(8'h01);
    host(1);
    $display("test basic done");
    run(2'h1, 1'b0);
    fa = 16'($urandom);
    // sync on both frame starts, then port 1 never delivers its line
    put(0, DT_FS, fa);
    put(1, DT_FS, fb);
    put(0, 6'h2A, 16'h0000);
    ex(0, DT_FS, fa, 8'hFF);
    ex(1, DT_FS, fb, 8'hFF);
    ex(0, 6'h2A, 16'h0000, 8'hFF);
    drain();
    repeat (1700) @(posedge clock_in);
    #1;
    stat(8'h02);
    stat(8'h00);
    put(0, 6'h2A, 16'h0000);
    repeat (60) @(posedge clock_in);
    #1;
    chk("dropped", 8'h00, 8'(bq[0].size()));
    put(0, DT_FS, fa);
    put(1, DT_FS, fb);
    ex(0, DT_FS, fa, 8'hFF);
    ex(1, DT_FS, fb, 8'hFF);
    drain();
    stat(8'h01);
    host(1);
    $display("test loss done");
    run(2'h2, 1'b0);
    frame(2'h2);
    drain();
    host(1);
    $display("test interleave done");
    run(2'h3, 1'b0);
    frame(2'h3);
    drain();
    host(1);
    $display("test concat done");
    close_out();
  end
endmodule // testbench
